// ---- rtl/ibam_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// R1: Stop seen set by stop, cleared by start
// R2: Start seen set by start, cleared by stop
// R3: Direction flag updated after address byte
// R4: Receive full set on byte, cleared on read
// R5: Transmit full set on write, cleared when sent
// R6: Twelve bit baud value divides peripheral clock
// R7: Software never loads divider with zero or one
// R8: Software computes divider from wanted rate
// R9: Ten bit own address, read and write
// R10: Mask bit one makes position don't care
// R11: Mask bit zero requires equal address bit
// R12: Mask bits 9:8 and 0 only ten bit
// R13: Unimplemented upper bits read as zero
// R14: Ten bit mode select picks address width
// R15: Divider reloads with count plus one each half period, so a half period is count plus two
module ibam_top
  import ibam_pkg::*;
#(
  parameter int BAUD_W = IBAM_BAUD_W,
  parameter int ADDR_W = IBAM_ADDR_W
)
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire logic                   start_det,
  input  wire logic                   stop_det,
  input  wire logic                   addr_byte_done,
  input  wire logic                   addr_byte_rw,
  input  wire logic                   rx_byte_strobe,
  input  wire logic [IBAM_BYTE_W-1:0] rx_byte,
  input  wire logic                   tx_byte_done,
  input  wire logic                   baud_run,
  input  wire logic                   match_req,
  input  wire logic [ADDR_W-1:0]      match_addr,
  output logic      [IBAM_BYTE_W-1:0] tx_byte,
  output logic                        tx_holding_full,
  output logic                        rx_holding_full,
  output logic                        ten_bit_mode_select,
  output logic                        scl_half_tick,
  output logic                        scl_phase,
  output logic                        match_valid,
  output logic                        match_hit,
  output logic                        irq
);

  // ********************************************************************
  // State registers
  // ********************************************************************
  logic                   stop_seen;
  logic                   start_seen;
  logic                   slave_read;
  logic [BAUD_W-1:0]      baud_divider;
  logic [ADDR_W-1:0]      own_node_id;
  logic [ADDR_W-1:0]      match_ignore_bits;
  logic [IBAM_BYTE_W-1:0] rx_holding_reg;
  logic [IBAM_IRQ_W-1:0]  irq_status;
  logic [IBAM_IRQ_W-1:0]  irq_mask;
  logic [BAUD_W:0]        half_count;

  logic                   next_stop_seen;
  logic                   next_start_seen;
  logic                   next_slave_read;
  logic [BAUD_W-1:0]      next_baud_divider;
  logic [ADDR_W-1:0]      next_own_node_id;
  logic [ADDR_W-1:0]      next_match_ignore_bits;
  logic [IBAM_BYTE_W-1:0] next_rx_holding_reg;
  logic [IBAM_BYTE_W-1:0] next_tx_byte;
  logic                   next_tx_holding_full;
  logic                   next_rx_holding_full;
  logic                   next_ten_bit_mode_select;
  logic [IBAM_IRQ_W-1:0]  next_irq_status;
  logic [IBAM_IRQ_W-1:0]  next_irq_mask;
  logic                   next_irq;
  logic [31:0]            next_reg_rdata;
  logic [BAUD_W:0]        next_half_count;
  logic                   next_scl_half_tick;
  logic                   next_scl_phase;
  logic                   next_match_valid;
  logic                   next_match_hit;

  logic                   wr_baud;
  logic                   wr_own;
  logic                   wr_mask;
  logic                   wr_tx;
  logic                   wr_ctrl;
  logic                   wr_irq_st;
  logic                   wr_irq_mk;
  logic                   rd_rx;
  logic [ADDR_W-1:0]      expect_addr;
  logic [ADDR_W-1:0]      care_bits;
  logic [ADDR_W-1:0]      bit_ok;
  logic [IBAM_IRQ_W-1:0]  irq_events;

  // ********************************************************************
  // Register decode
  // ********************************************************************

  // Strobes are one cycle wide, so each decoded term is a pulse too
  assign wr_baud   = reg_wr && (reg_addr == IBAM_OFS_BAUD);
  assign wr_own    = reg_wr && (reg_addr == IBAM_OFS_OWN_ID);
  assign wr_mask   = reg_wr && (reg_addr == IBAM_OFS_MASK);
  assign wr_tx     = reg_wr && (reg_addr == IBAM_OFS_TX_HOLD);
  assign wr_ctrl   = reg_wr && (reg_addr == IBAM_OFS_CTRL);
  assign wr_irq_st = reg_wr && (reg_addr == IBAM_OFS_IRQ_STATUS);
  assign wr_irq_mk = reg_wr && (reg_addr == IBAM_OFS_IRQ_MASK);
  assign rd_rx     = reg_rd && (reg_addr == IBAM_OFS_RX_HOLD);

  // ********************************************************************
  // Address comparison
  // ********************************************************************

  // Seven bit address sits in bits 7:1 of the address byte; bit 0 is R/W
  assign expect_addr = ten_bit_mode_select ? own_node_id               // R14
                                           : {{(ADDR_W-8){1'b0}}, own_node_id[6:0], 1'b0};
  // Outer mask bits drop out in seven bit mode since those positions never count
  assign care_bits   = ~match_ignore_bits                               // R10
                       & (ten_bit_mode_select ? IBAM_CARE_TEN : IBAM_CARE_SEVEN); // R12

  // Per bit compare, masked positions always agree
  genvar gi;
  generate
    for (gi = 0; gi < ADDR_W; gi = gi + 1)
    begin : g_cmp
      assign bit_ok[gi] = !care_bits[gi] || (match_addr[gi] == expect_addr[gi]); // R11
    end
  endgenerate

  // Events that feed the sticky interrupt bits
  assign irq_events = {match_req && (&bit_ok), tx_byte_done,
                       rx_byte_strobe, stop_det, start_det};

  // ********************************************************************
  // Next state
  // ********************************************************************

  // Status flags, holding registers and configuration
  always_comb
  begin
    next_stop_seen           = stop_seen;
    next_start_seen          = start_seen;
    next_slave_read          = slave_read;
    next_baud_divider        = baud_divider;
    next_own_node_id         = own_node_id;
    next_match_ignore_bits   = match_ignore_bits;
    next_rx_holding_reg      = rx_holding_reg;
    next_tx_byte             = tx_byte;
    next_tx_holding_full     = tx_holding_full;
    next_rx_holding_full     = rx_holding_full;
    next_ten_bit_mode_select = ten_bit_mode_select;
    next_irq_mask            = irq_mask;
    // Last condition wins; a stop in the same cycle as a start is taken as latest
    if (start_det)
    begin
      next_start_seen = 1'b1;                                           // R2
      next_stop_seen  = 1'b0;                                           // R1
    end
    if (stop_det)
    begin
      next_stop_seen  = 1'b1;                                           // R1
      next_start_seen = 1'b0;                                           // R2
    end
    if (addr_byte_done)
    begin
      next_slave_read = addr_byte_rw;                                   // R3
    end
    // Clear by read first, so a new byte in the same cycle keeps the flag
    if (rd_rx)
    begin
      next_rx_holding_full = 1'b0;                                      // R4
    end
    if (rx_byte_strobe)
    begin
      next_rx_holding_reg  = rx_byte;
      next_rx_holding_full = 1'b1;                                      // R4
    end
    if (tx_byte_done)
    begin
      next_tx_holding_full = 1'b0;                                      // R5
    end
    if (wr_tx)
    begin
      next_tx_byte         = reg_wdata[IBAM_BYTE_W-1:0];
      next_tx_holding_full = 1'b1;                                      // R5
    end
    if (wr_baud)
    begin
      next_baud_divider = reg_wdata[BAUD_W-1:0];                        // R6
    end
    if (wr_own)
    begin
      next_own_node_id = reg_wdata[ADDR_W-1:0];                         // R9
    end
    if (wr_mask)
    begin
      next_match_ignore_bits = reg_wdata[ADDR_W-1:0];
    end
    if (wr_ctrl)
    begin
      next_ten_bit_mode_select = reg_wdata[IBAM_CTRL_TEN];              // R14
    end
    if (wr_irq_mk)
    begin
      next_irq_mask = reg_wdata[IBAM_IRQ_W-1:0];
    end
    // Write one to clear; a fresh event in the same cycle wins over the clear
    next_irq_status = irq_status;
    if (wr_irq_st)
    begin
      next_irq_status = irq_status & ~reg_wdata[IBAM_IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
    next_irq        = |(next_irq_status & next_irq_mask);
  end

  // Read data, valid only in the cycle after the strobe
  always_comb
  begin
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      case (reg_addr)
        IBAM_OFS_BUS_STATUS:
        begin
          next_reg_rdata[IBAM_STAT_TXF] = tx_holding_full;
          next_reg_rdata[IBAM_STAT_RXF] = rx_holding_full;
          next_reg_rdata[IBAM_STAT_DIR] = slave_read;
          next_reg_rdata[IBAM_STAT_STA] = start_seen;
          next_reg_rdata[IBAM_STAT_STO] = stop_seen;
        end
        IBAM_OFS_BAUD:       next_reg_rdata[BAUD_W-1:0] = baud_divider;      // R13
        IBAM_OFS_OWN_ID:     next_reg_rdata[ADDR_W-1:0] = own_node_id;       // R13
        IBAM_OFS_MASK:       next_reg_rdata[ADDR_W-1:0] = match_ignore_bits; // R13
        IBAM_OFS_RX_HOLD:    next_reg_rdata[IBAM_BYTE_W-1:0] = rx_holding_reg;
        IBAM_OFS_TX_HOLD:    next_reg_rdata[IBAM_BYTE_W-1:0] = tx_byte;
        IBAM_OFS_CTRL:       next_reg_rdata[IBAM_CTRL_TEN] = ten_bit_mode_select;
        IBAM_OFS_IRQ_STATUS: next_reg_rdata[IBAM_IRQ_W-1:0] = irq_status;
        IBAM_OFS_IRQ_MASK:   next_reg_rdata[IBAM_IRQ_W-1:0] = irq_mask;
        default:             next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Half period timer; zero or one in the divider is the user's hazard, not guarded
  always_comb
  begin
    next_half_count    = half_count;
    next_scl_half_tick = 1'b0;
    next_scl_phase     = scl_phase;
    if (!baud_run)
    begin
      // Idle holds the count loaded so the first phase is full length
      next_half_count = {1'b0, baud_divider} + IBAM_HALF_EXTRA;          // R15
      next_scl_phase  = 1'b0;
    end
    else if (half_count == '0)
    begin
      next_half_count    = {1'b0, baud_divider} + IBAM_HALF_EXTRA;       // R15
      next_scl_half_tick = 1'b1;                                        // R6
      next_scl_phase     = !scl_phase;
    end
    else
    begin
      next_half_count = half_count - 1'b1;
    end
  end

  // Match answer registered one cycle after the request
  always_comb
  begin
    next_match_valid = match_req;
    next_match_hit   = match_req && (&bit_ok);                          // R10
  end

  // ********************************************************************
  // Registers
  // ********************************************************************

  // Synchronous reset, every flop takes a constant
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      stop_seen           <= 1'b0;
      start_seen          <= 1'b0;
      slave_read          <= 1'b0;
      baud_divider        <= IBAM_BAUD_RST;
      own_node_id         <= IBAM_ADDR_RST;
      match_ignore_bits   <= IBAM_MASK_RST;
      rx_holding_reg      <= '0;
      tx_byte             <= '0;
      tx_holding_full     <= 1'b0;
      rx_holding_full     <= 1'b0;
      ten_bit_mode_select <= 1'b0;
      irq_status          <= '0;
      irq_mask            <= '0;
      irq                 <= 1'b0;
      reg_rdata           <= 32'h0000_0000;
      half_count          <= '0;
      scl_half_tick       <= 1'b0;
      scl_phase           <= 1'b0;
      match_valid         <= 1'b0;
      match_hit           <= 1'b0;
    end
    else
    begin
      stop_seen           <= next_stop_seen;
      start_seen          <= next_start_seen;
      slave_read          <= next_slave_read;
      baud_divider        <= next_baud_divider;
      own_node_id         <= next_own_node_id;
      match_ignore_bits   <= next_match_ignore_bits;
      rx_holding_reg      <= next_rx_holding_reg;
      tx_byte             <= next_tx_byte;
      tx_holding_full     <= next_tx_holding_full;
      rx_holding_full     <= next_rx_holding_full;
      ten_bit_mode_select <= next_ten_bit_mode_select;
      irq_status          <= next_irq_status;
      irq_mask            <= next_irq_mask;
      irq                 <= next_irq;
      reg_rdata           <= next_reg_rdata;
      half_count          <= next_half_count;
      scl_half_tick       <= next_scl_half_tick;
      scl_phase           <= next_scl_phase;
      match_valid         <= next_match_valid;
      match_hit           <= next_match_hit;
    end
  end

endmodule // ibam_top

// ---- rtl/ibam_pkg.sv ----
package ibam_pkg;

  // ********************************************************************
  // Register map, word aligned byte addresses
  // ********************************************************************
  localparam logic [7:0] IBAM_OFS_BUS_STATUS  = 8'h00;
  localparam logic [7:0] IBAM_OFS_BAUD        = 8'h04;
  localparam logic [7:0] IBAM_OFS_OWN_ID      = 8'h08;
  localparam logic [7:0] IBAM_OFS_MASK        = 8'h0C;
  localparam logic [7:0] IBAM_OFS_RX_HOLD     = 8'h10;
  localparam logic [7:0] IBAM_OFS_TX_HOLD     = 8'h14;
  localparam logic [7:0] IBAM_OFS_CTRL        = 8'h18;
  localparam logic [7:0] IBAM_OFS_IRQ_STATUS  = 8'h1C;
  localparam logic [7:0] IBAM_OFS_IRQ_MASK    = 8'h20;

  // ********************************************************************
  // Field positions and widths
  // ********************************************************************
  localparam int IBAM_BAUD_W   = 12;
  localparam int IBAM_ADDR_W   = 10;
  localparam int IBAM_BYTE_W   = 8;
  localparam int IBAM_IRQ_W    = 5;
  localparam int IBAM_STAT_TXF = 0;
  localparam int IBAM_STAT_RXF = 1;
  localparam int IBAM_STAT_DIR = 2;
  localparam int IBAM_STAT_STA = 3;
  localparam int IBAM_STAT_STO = 4;
  localparam int IBAM_CTRL_TEN = 0;
  localparam int IBAM_IRQ_STA  = 0;
  localparam int IBAM_IRQ_STO  = 1;
  localparam int IBAM_IRQ_RXF  = 2;
  localparam int IBAM_IRQ_TXD  = 3;
  localparam int IBAM_IRQ_MAT  = 4;

  // ********************************************************************
  // Values after reset and fixed counts
  // ********************************************************************
  localparam logic [11:0] IBAM_BAUD_RST   = 12'h000;
  localparam logic [9:0]  IBAM_ADDR_RST   = 10'h000;
  localparam logic [9:0]  IBAM_MASK_RST   = 10'h000;
  localparam logic [12:0] IBAM_HALF_EXTRA = 13'h0001;
  localparam logic [9:0]  IBAM_CARE_TEN   = 10'h3FF;
  localparam logic [9:0]  IBAM_CARE_SEVEN = 10'h0FE;

endpackage : ibam_pkg

// ---- dv/ibam_checker_sva.sv ----
`timescale 1ns/1ps
// ************************************************************
// Port checker for flags, divider and address match
// ************************************************************
module ibam_checker
  import ibam_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        rx_byte_strobe,
  input wire logic        tx_byte_done,
  input wire logic        baud_run,
  input wire logic        match_req,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_holding_full,
  input wire logic        rx_holding_full,
  input wire logic        scl_half_tick,
  input wire logic        scl_phase,
  input wire logic        match_valid,
  input wire logic        match_hit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Read port: registered answer, zero outside the answer cycle
  chk_rd_upper_zero: assert property (
    reg_rd |=> reg_rdata[31:12] == 20'h0) else $error("read data upper bits set");
  chk_rd_idle_zero: assert property (
    !reg_rd |=> reg_rdata == 32'h0) else $error("read data not zero when idle");
  // Holding flags follow their set and clear events
  chk_rx_full_set: assert property (
    rx_byte_strobe |=> rx_holding_full) else $error("receive flag not set");
  chk_rx_full_clear: assert property (
    rx_holding_full && reg_rd && reg_addr == IBAM_OFS_RX_HOLD && !rx_byte_strobe
    |=> !rx_holding_full) else $error("receive flag not cleared by read");
  chk_tx_full_set: assert property (
    reg_wr && reg_addr == IBAM_OFS_TX_HOLD |=> tx_holding_full
    && tx_byte == $past(reg_wdata[7:0])) else $error("transmit flag or byte wrong");
  chk_tx_full_clear: assert property (
    tx_byte_done && !(reg_wr && reg_addr == IBAM_OFS_TX_HOLD)
    |=> !tx_holding_full) else $error("transmit flag not cleared");
  // Divider: legal values give at least four cycles per half period
  chk_tick_spacing: assert property (
    scl_half_tick |=> !scl_half_tick [*3]) else $error("half period too short");
  chk_phase_toggle: assert property (
    scl_half_tick && $past(baud_run) |-> scl_phase != $past(scl_phase))
    else $error("phase did not toggle at tick");
  chk_phase_idle: assert property (
    !baud_run |=> !scl_phase) else $error("phase high while divider stopped");
  // Match answers exactly one cycle after the request
  chk_match_answer: assert property (
    match_req |=> match_valid) else $error("match answer missing");
  chk_match_cause: assert property (
    match_valid |-> $past(match_req)) else $error("match answer without request");
  chk_match_quiet: assert property (
    !match_valid |-> !match_hit) else $error("hit outside answer cycle");

  cov_hit: cover property (match_valid && match_hit);
  cov_miss: cover property (match_valid && !match_hit);
  cov_tick: cover property (scl_half_tick);
endmodule // ibam_checker

bind ibam_top ibam_checker ibam_checker_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_byte_strobe(rx_byte_strobe), .tx_byte_done(tx_byte_done), .baud_run(baud_run),
  .match_req(match_req), .tx_byte(tx_byte), .tx_holding_full(tx_holding_full),
  .rx_holding_full(rx_holding_full), .scl_half_tick(scl_half_tick),
  .scl_phase(scl_phase), .match_valid(match_valid), .match_hit(match_hit));

// ---- dv/ibam_bus_peer.sv ----
`timescale 1ns/1ps
// ************************************************************
// Far side: bus condition detectors and byte engine events
// ************************************************************
module ibam_bus_peer
(
  input  wire logic  clk_sys,
  output logic       start_det,
  output logic       stop_det,
  output logic       addr_byte_done,
  output logic       addr_byte_rw,
  output logic       rx_byte_strobe,
  output logic [7:0] rx_byte,
  output logic       tx_byte_done,
  output logic       match_req,
  output logic [9:0] match_addr
);
  initial
  begin
    {start_det, stop_det, addr_byte_done, rx_byte_strobe, tx_byte_done, match_req} = '0;
    {addr_byte_rw, rx_byte, match_addr} = '0;
  end

  // Kinds: 0 start, 1 stop, 2 address, 3 byte in, 4 byte out, 5 match, 6 start and stop
  task automatic pulse(input int k, input logic [9:0] d);
    @(posedge clk_sys);
    start_det      <= (k == 0 || k == 6);
    stop_det       <= (k == 1 || k == 6);
    addr_byte_done <= (k == 2);
    rx_byte_strobe <= (k == 3);
    tx_byte_done   <= (k == 4);
    match_req      <= (k == 5);
    {addr_byte_rw, rx_byte, match_addr} <= {d[0], d[7:0], d};
    @(posedge clk_sys);
    {start_det, stop_det, addr_byte_done, rx_byte_strobe, tx_byte_done, match_req} <= '0;
    // Data is stale once the pulse ends, so show its inverse
    {addr_byte_rw, rx_byte, match_addr} <= ~{d[0], d[7:0], d};
  endtask
endmodule // ibam_bus_peer

// ---- dv/i2c_status_baud_addr_match_test.sv ----
`timescale 1ns/1ps
// ************************************************************
// Register level tests of flags, divider and match
// ************************************************************
module i2c_status_baud_addr_match_test
  import ibam_pkg::*;
;
  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        baud_run  = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  rx_byte, tx_byte;
  logic [9:0]  match_addr;
  // Expected hits against own 2A5: exact, bit 0 off, masked, seven bit, masked, bit 2 off
  logic [5:0]  hits = 6'h1D;
  logic        start_det, stop_det, addr_byte_done, addr_byte_rw, rx_byte_strobe;
  logic        tx_byte_done, match_req, tx_holding_full, rx_holding_full;
  logic        ten_bit_mode_select, scl_half_tick, scl_phase, match_valid, match_hit, irq;
  logic [5:0]  ten = 6'h07;
  logic [9:0]  msk [6] = '{10'h000, 10'h000, 10'h301, 10'h000, 10'h004, 10'h000};
  logic [9:0]  adr [6] = '{10'h2A5, 10'h2A4, 10'h0A4, 10'h34B, 10'h04E, 10'h04E};
  logic [9:0]  own = 10'h2A5;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n;

  ibam_top ibam_top_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_det(start_det),
    .stop_det(stop_det), .addr_byte_done(addr_byte_done), .addr_byte_rw(addr_byte_rw),
    .rx_byte_strobe(rx_byte_strobe), .rx_byte(rx_byte), .tx_byte_done(tx_byte_done),
    .baud_run(baud_run), .match_req(match_req), .match_addr(match_addr),
    .tx_byte(tx_byte), .tx_holding_full(tx_holding_full),
    .rx_holding_full(rx_holding_full), .ten_bit_mode_select(ten_bit_mode_select),
    .scl_half_tick(scl_half_tick), .scl_phase(scl_phase), .match_valid(match_valid),
    .match_hit(match_hit), .irq(irq));

  ibam_bus_peer ibam_bus_peer_i (
    .clk_sys(clk_sys), .start_det(start_det), .stop_det(stop_det),
    .addr_byte_done(addr_byte_done), .addr_byte_rw(addr_byte_rw),
    .rx_byte_strobe(rx_byte_strobe), .rx_byte(rx_byte), .tx_byte_done(tx_byte_done),
    .match_req(match_req), .match_addr(match_addr));

  always #10 clk_sys = ~clk_sys;

  // Cut a hang short; the whole run needs well under this
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Bus cycles; each returns just after the edge that took the strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic peer(input int k, input logic [9:0] d);
    ibam_bus_peer_i.pulse(k, d);
    #1;
  endtask

  task automatic gap(output int c);
    c = 0;
    do
    begin
      @(posedge clk_sys);
      #1 c++;
    end
    while (scl_half_tick !== 1'b1 && c < 99);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values, unmapped word at the end
    for (int a = 0; a <= 36; a += 4) rd(8'(a), 32'h0);
    wr(IBAM_OFS_BAUD, 32'hFFFFFFFF);
    rd(IBAM_OFS_BAUD, 32'h00000FFF);
    wr(IBAM_OFS_OWN_ID, 32'hFFFFFFFF);
    rd(IBAM_OFS_OWN_ID, 32'h000003FF);
    wr(IBAM_OFS_MASK, 32'hFFFFFFFF);
    rd(IBAM_OFS_MASK, 32'h000003FF);
    // Conditions, with only the start event unmasked
    wr(IBAM_OFS_IRQ_MASK, 32'h1);
    peer(1, 10'h0);
    rd(IBAM_OFS_BUS_STATUS, 32'h10);
    chk({31'h0, irq}, 32'h0);
    peer(0, 10'h0);
    rd(IBAM_OFS_BUS_STATUS, 32'h08);
    chk({31'h0, irq}, 32'h1);
    rd(IBAM_OFS_IRQ_STATUS, 32'h3);
    wr(IBAM_OFS_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(IBAM_OFS_IRQ_STATUS, 32'h2);
    peer(6, 10'h0);
    rd(IBAM_OFS_BUS_STATUS, 32'h10);
    peer(2, 10'h1);
    rd(IBAM_OFS_BUS_STATUS, 32'h14);
    peer(2, 10'h0);
    rd(IBAM_OFS_BUS_STATUS, 32'h10);
    // Holding registers
    peer(3, 10'h0A5);
    chk({31'h0, rx_holding_full}, 32'h1);
    rd(IBAM_OFS_BUS_STATUS, 32'h12);
    rd(IBAM_OFS_RX_HOLD, 32'hA5);
    chk({31'h0, rx_holding_full}, 32'h0);
    wr(IBAM_OFS_TX_HOLD, 32'h13C);
    chk({31'h0, tx_holding_full}, 32'h1);
    rd(IBAM_OFS_TX_HOLD, 32'h3C);
    peer(4, 10'h0);
    chk({31'h0, tx_holding_full}, 32'h0);
    rd(IBAM_OFS_IRQ_STATUS, 32'hF);
    // Address match over both widths and masks
    wr(IBAM_OFS_OWN_ID, {22'h0, own});
    for (int i = 0; i < 6; i++)
    begin
      wr(IBAM_OFS_CTRL, {31'h0, ten[i]});
      wr(IBAM_OFS_MASK, {22'h0, msk[i]});
      peer(5, adr[i]);
      chk({31'h0, ten_bit_mode_select}, {31'h0, ten[i]});
      chk({31'h0, match_valid}, 32'h1);
      chk({31'h0, match_hit}, {31'h0, hits[i]});
    end
    rd(IBAM_OFS_IRQ_STATUS, 32'h1F);
    // Divider half period is the loaded value plus two
    for (int b = 2; b <= 5; b += 3)
    begin
      @(posedge clk_sys);
      baud_run <= 1'b0;
      wr(IBAM_OFS_BAUD, 32'(b));
      @(posedge clk_sys);
      baud_run <= 1'b1;
      gap(n);
      gap(n);
      chk(32'(n), 32'(b + 2));
    end
    conclude();
  end
endmodule // i2c_status_baud_addr_match_test
